// ---- rtl/gudc_aux_filter.sv ----
// Purpose: synchronise, invert and filter the auxiliary input
// Assumes: raw input is asynchronous to clock
// Notes:   a level is accepted once it has stood filterCycles + 1 cycles
`timescale 1ns/10ps
`default_nettype none
module gudc_aux_filter #(
   parameter int CW = gudc_pkg::CNT16_W
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rstn,
   // configuration
   input  wire logic          invert,
   input  wire logic          filterOn,
   input  wire logic [CW-1:0] filterCycles,
   // pin and result
   input  wire logic          rawIn,
   output logic               level
);
   typedef struct packed {
      logic [2:0]    sync;
      logic          stable;
      logic          level;
      logic [CW-1:0] run;
   } gudc_flt_t;

   gudc_flt_t s_q, s_d;
   logic      agreed;

   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], rawIn};
      // first stage is only read by the second
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.stable = s_q.sync[2] ^ invert;
      end
      agreed = s_q.stable;
      // filter is ahead of any edge detection downstream
      if (!filterOn || agreed == s_q.level) begin
         s_d.run = '0;
         s_d.level = filterOn ? s_q.level : agreed;
      end else if (s_q.run >= filterCycles) begin
         s_d.run = '0;
         s_d.level = agreed;
      end else begin
         s_d.run = s_q.run + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.level;
endmodule
`default_nettype wire

// ---- rtl/gudc_counter.sv ----
// Purpose: 32-bit gated up/down counter with once-only and periodic modes
// Assumes: count pulses come from same-clock logic as one-cycle strobes
// Notes:   cycle tick marks the output instant, input tick the input
//          instant of an isochronous bus cycle
`timescale 1ns/10ps
`default_nettype none
module gudc_counter (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // configuration, applied on cfgApply
   input  wire gudc_pkg::gudc_cfg_t   cfg,
   input  wire logic                  cfgApply,
   // count pulses
   input  wire logic                  cntPulse,
   input  wire logic                  cntUp,
   // run-time control
   input  wire logic                  soft_gate_bit,
   input  wire logic                  pendingLoadWr,
   input  wire logic signed [31:0]    pending_load_value,
   input  wire logic                  directCountWr,
   input  wire logic signed [31:0]    direct_count_write,
   input  wire logic signed [31:0]    compare_value_one,
   input  wire logic signed [31:0]    compare_value_two,
   input  wire gudc_pkg::gudc_outcfg_t outCfgOne,
   input  wire gudc_pkg::gudc_outcfg_t outCfgTwo,
   // isochronous instants
   input  wire logic                  outTick,
   input  wire logic                  inTick,
   // pins
   input  wire logic                  aux_input,
   output logic                       output_one,
   output logic                       output_two,
   // feedback
   output logic signed [31:0]         countValue,
   output logic signed [31:0]         latchValue,
   output logic                       internal_gate_flag,
   output logic                       aux_input_level_flag
);
   typedef struct packed {
      logic signed [31:0] count;
      logic signed [31:0] loadVal;
      logic signed [31:0] latch;
      logic signed [31:0] report;
      gudc_pkg::gudc_cfg_t cfg;
      logic               swCtlPrev;
      logic               swGate;
      logic               swArmed;
      logic               hwGate;
      logic               auxPrev;
      logic               gatePrev;
      logic               gateFlag;
      logic               outOne;
      logic               outTwo;
      logic               auxFlag;
      logic [15:0]        pulseOne;
      logic [15:0]        pulseTwo;
      logic               switchOne;
   } gudc_state_t;

   gudc_state_t s_q, s_d;

   logic               auxLvl;
   logic               invEff;
   logic               auxRise;
   logic               auxFall;
   logic               gateOpen;
   logic               opening;
   logic               hwAssigned;
   logic signed [31:0] highLim;
   logic signed [32:0] nextWide;
   logic signed [31:0] nextCnt;
   logic               hitHigh;
   logic               hitLow;
   logic               closeAuto;
   logic               cmpOneEq;
   logic               cmpTwoEq;

   // ------------------------------------------------------------------
   // aux input conditioning
   // ------------------------------------------------------------------
   assign invEff = s_q.cfg.auxInvert &&
                   (s_q.cfg.auxFunc != gudc_pkg::AUXF_LATCH);

   gudc_aux_filter #(
      .CW(gudc_pkg::CNT16_W)
   ) u_filter (
      .clock        (clock),
      .rstn         (rstn),
      .invert       (invEff),
      .filterOn     (s_q.cfg.filterOn),
      .filterCycles (s_q.cfg.filterCycles),
      .rawIn        (aux_input),
      .level        (auxLvl)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      closeAuto = 1'b0;
      hitHigh = 1'b0;
      hitLow = 1'b0;
      nextWide = '0;
      nextCnt = s_q.count;
      hwAssigned = (s_q.cfg.auxFunc == gudc_pkg::AUXF_GATE);
      highLim = s_q.cfg.highLimit;
      auxRise = auxLvl && !s_q.auxPrev;
      auxFall = !auxLvl && s_q.auxPrev;
      s_d.auxPrev = auxLvl;
      s_d.auxFlag = auxLvl;

      // ---------------------------------------------------------------
      // soft gate
      // ---------------------------------------------------------------
      // edge-armed, opened at output instant when isochronous; a bit held
      // high across a reconfiguration never reopens the gate by itself
      s_d.swCtlPrev = soft_gate_bit;
      if (!soft_gate_bit) begin
         s_d.swGate = 1'b0;
         s_d.swArmed = 1'b0;
      end else if (!s_q.swCtlPrev) begin
         if (s_q.cfg.isoMode) begin
            s_d.swArmed = 1'b1;
         end else begin
            s_d.swGate = 1'b1;
         end
      end
      if (s_q.swArmed && soft_gate_bit && outTick) begin
         s_d.swGate = 1'b1;
         s_d.swArmed = 1'b0;
      end

      // ---------------------------------------------------------------
      // hardware gate and internal gate
      // ---------------------------------------------------------------
      // an unassigned input leaves the hardware gate shut but ignored
      if (!hwAssigned) begin
         s_d.hwGate = 1'b0;
      end else if (auxRise) begin
         s_d.hwGate = 1'b1;
      end else if (auxFall) begin
         s_d.hwGate = 1'b0;
      end

      gateOpen = s_q.swGate && (s_q.hwGate || !hwAssigned);
      opening = gateOpen && !s_q.gatePrev;
      s_d.gatePrev = gateOpen;

      // ---------------------------------------------------------------
      // run-time values
      // ---------------------------------------------------------------
      // run-time updates never stop counting
      if (pendingLoadWr) begin
         s_d.loadVal = pending_load_value;
      end

      // ---------------------------------------------------------------
      // counting and limits
      // ---------------------------------------------------------------
      // opening load and counting share one chain, so a pulse in the
      // opening cycle is dropped rather than applied on top of the load;
      // the 33-bit step is cut to 32 bits; full-range limits are caught by comparing the old count with CNT_MAX and CNT_MIN
      if (opening && (s_q.cfg.cancelGate ||
                      (s_q.cfg.loadOnOpen && !hwAssigned))) begin
         s_d.count = s_q.loadVal;
      end else if (gateOpen && cntPulse) begin
         // direction of each pulse decides, main direction only sets limits
         nextWide = cntUp ? 33'(s_q.count) + 33'sd1
                          : 33'(s_q.count) - 33'sd1;
         nextCnt = nextWide[31:0];
         unique case (s_q.cfg.dir)
            gudc_pkg::DIR_UP: begin
               hitHigh = cntUp && (nextCnt >= highLim);
            end
            gudc_pkg::DIR_DOWN: begin
               hitLow = !cntUp && (nextCnt <= gudc_pkg::CNT_ZERO);
            end
            default: begin
               hitHigh = cntUp && (s_q.count == gudc_pkg::CNT_MAX);
               hitLow = !cntUp && (s_q.count == gudc_pkg::CNT_MIN);
            end
         endcase
         if (hitHigh || hitLow) begin
            if (s_q.cfg.mode == gudc_pkg::MODE_ONCE) begin
               closeAuto = 1'b1;
               if (s_q.cfg.dir == gudc_pkg::DIR_NONE) begin
                  s_d.count = s_q.count;
               end else begin
                  s_d.count = s_q.loadVal;
               end
            end else begin
               s_d.count = s_q.loadVal;
            end
         end else begin
            s_d.count = nextCnt;
         end
      end

      // ---------------------------------------------------------------
      // automatic closure and direct write
      // ---------------------------------------------------------------
      // device never reopens by itself; controller must toggle again
      if (closeAuto) begin
         s_d.swGate = 1'b0;
         s_d.swArmed = 1'b0;
      end

      if (directCountWr) begin
         s_d.count = direct_count_write;
      end

      // ---------------------------------------------------------------
      // latch and feedback
      // ---------------------------------------------------------------
      // latch edges see the uninverted level
      if (s_q.cfg.auxFunc == gudc_pkg::AUXF_LATCH && auxRise) begin
         s_d.latch = s_q.count;
      end

      s_d.gateFlag = gateOpen;

      // feedback count sampled at input instant in isochronous mode
      if (!s_q.cfg.isoMode || inTick) begin
         s_d.report = s_q.count;
      end

      // ---------------------------------------------------------------
      // output functions
      // ---------------------------------------------------------------
      cmpOneEq = (s_q.count == compare_value_one);
      cmpTwoEq = (s_q.count == compare_value_two);
      if (cmpOneEq) begin
         s_d.switchOne = 1'b1;
      end else if (cmpTwoEq) begin
         s_d.switchOne = 1'b0;
      end
      s_d.pulseOne = (s_q.pulseOne != 16'h0000) ? s_q.pulseOne - 16'h0001
                                                : 16'h0000;
      s_d.pulseTwo = (s_q.pulseTwo != 16'h0000) ? s_q.pulseTwo - 16'h0001
                                                : 16'h0000;
      // pulse starts as the count moves onto the compare value, so a
      // count that rests on it does not retrigger
      if (s_d.count == compare_value_one && s_q.count != s_d.count) begin
         s_d.pulseOne = outCfgOne.pulseCycles;
      end
      if (s_d.count == compare_value_two && s_q.count != s_d.count) begin
         s_d.pulseTwo = outCfgTwo.pulseCycles;
      end
      s_d.outOne = 1'b0;
      s_d.outTwo = 1'b0;
      if (outCfgOne.enable) begin
         unique case (outCfgOne.fn)
            gudc_pkg::OUTF_PLAIN:  s_d.outOne = outCfgOne.setLevel;
            gudc_pkg::OUTF_GE:     s_d.outOne =
                                      s_q.count >= compare_value_one;
            gudc_pkg::OUTF_LE:     s_d.outOne =
                                      s_q.count <= compare_value_one;
            gudc_pkg::OUTF_PULSE:  s_d.outOne = s_q.pulseOne != 16'h0000;
            gudc_pkg::OUTF_SWITCH: s_d.outOne = s_q.switchOne;
            default:               s_d.outOne = 1'b0;
         endcase
      end
      if (outCfgTwo.enable) begin
         unique case (outCfgTwo.fn)
            gudc_pkg::OUTF_PLAIN:  s_d.outTwo = outCfgTwo.setLevel;
            gudc_pkg::OUTF_GE:     s_d.outTwo =
                                      s_q.count >= compare_value_two;
            gudc_pkg::OUTF_LE:     s_d.outTwo =
                                      s_q.count <= compare_value_two;
            gudc_pkg::OUTF_PULSE:  s_d.outTwo = s_q.pulseTwo != 16'h0000;
            // switch-between is refused on output two
            default:               s_d.outTwo = 1'b0;
         endcase
      end

      // ---------------------------------------------------------------
      // configuration apply
      // ---------------------------------------------------------------
      // applied last so it wins over every other update this cycle;
      // configuration resets values by main direction
      if (cfgApply) begin
         s_d.cfg = cfg;
         s_d.swGate = 1'b0;
         s_d.swArmed = 1'b0;
         s_d.hwGate = 1'b0;
         if (cfg.dir == gudc_pkg::DIR_DOWN) begin
            s_d.loadVal = cfg.highLimit;
            s_d.count = cfg.highLimit;
            s_d.latch = cfg.highLimit;
         end else begin
            s_d.loadVal = gudc_pkg::CNT_ZERO;
            s_d.count = gudc_pkg::CNT_ZERO;
            s_d.latch = gudc_pkg::CNT_ZERO;
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // feedback and pins
   // ------------------------------------------------------------------
   // every port below is a plain flop output
   assign countValue = s_q.report;
   assign latchValue = s_q.latch;
   assign internal_gate_flag = s_q.gateFlag;
   assign aux_input_level_flag = s_q.auxFlag;
   assign output_one = s_q.outOne;
   assign output_two = s_q.outTwo;
endmodule
`default_nettype wire

// ---- rtl/gudc_pkg.sv ----
// Purpose: shared types and constants of the gated up/down counter
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes:   counter values are signed 32-bit two's complement
package gudc_pkg;

   localparam int CNT_W = 32;
   localparam logic signed [31:0] CNT_MAX = 32'sh7fffffff;
   localparam logic signed [31:0] CNT_MIN = 32'sh80000000;
   localparam logic signed [31:0] CNT_ZERO = 32'sh00000000;
   localparam logic signed [31:0] HIGH_LIMIT_RST = 32'sh000003e8;

   localparam int CLK_MHZ = 125;
   localparam int PULSE_NS = 1000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_NS = 40;
   localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT16_W = 16;

   typedef enum logic [1:0] {
      MODE_ONCE     = 2'b00,
      MODE_PERIODIC = 2'b01
   } gudc_mode_t;

   typedef enum logic [1:0] {
      DIR_NONE = 2'b00,
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } gudc_dir_t;

   typedef enum logic [1:0] {
      AUXF_INPUT = 2'b00,
      AUXF_GATE  = 2'b01,
      AUXF_LATCH = 2'b10,
      AUXF_SYNC  = 2'b11
   } gudc_auxf_t;

   typedef enum logic [2:0] {
      OUTF_PLAIN  = 3'b000,
      OUTF_GE     = 3'b001,
      OUTF_LE     = 3'b010,
      OUTF_PULSE  = 3'b011,
      OUTF_SWITCH = 3'b100
   } gudc_outf_t;

   typedef struct packed {
      gudc_outf_t           fn;
      logic                 enable;
      logic                 setLevel;
      logic [CNT16_W-1:0]   pulseCycles;
   } gudc_outcfg_t;

   typedef struct packed {
      gudc_mode_t           mode;
      gudc_dir_t            dir;
      logic signed [31:0]   highLimit;
      gudc_auxf_t           auxFunc;
      logic                 auxInvert;
      logic                 filterOn;
      logic [CNT16_W-1:0]   filterCycles;
      logic                 cancelGate;
      logic                 loadOnOpen;
      logic                 isoMode;
   } gudc_cfg_t;

endpackage

// ---- test/gudc_counter_asserts.sv ----
// Purpose: port-level temporal checks of the gated up/down counter
// Assumes: cfg is set together with cfgApply and then held
// Notes:   iso reporting and the hardware gate lag, so some are masked
`timescale 1ns/10ps
`default_nettype none
module gudc_counter_asserts (
   // clock and reset
   input wire logic                   clock,
   input wire logic                   rstn,
   // control
   input wire gudc_pkg::gudc_cfg_t    cfg,
   input wire logic                   cfgApply,
   input wire logic                   cntPulse,
   input wire logic                   cntUp,
   input wire logic                   soft_gate_bit,
   input wire logic                   directCountWr,
   input wire logic signed [31:0]     compare_value_one,
   input wire gudc_pkg::gudc_outcfg_t outCfgOne,
   input wire gudc_pkg::gudc_outcfg_t outCfgTwo,
   input wire logic                   aux_input,
   // observed
   input wire logic                   output_one,
   input wire logic                   output_two,
   input wire logic signed [31:0]     countValue,
   input wire logic                   internal_gate_flag,
   input wire logic                   aux_input_level_flag
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   wire logic plain = !cfg.isoMode && cfg.auxFunc != gudc_pkg::AUXF_GATE;
   wire logic quiet = !directCountWr && !cfgApply;
   sequence s_rise;
      !soft_gate_bit ##1 soft_gate_bit;
   endsequence
   sequence s_held;
      soft_gate_bit [*4];
   endsequence
   soft_open_a: assert property (
      s_rise ##0 (plain && !cfgApply) ##1 (soft_gate_bit && !cfgApply)
      |=> internal_gate_flag) else $error("soft gate did not open");
   soft_close_a: assert property (
      plain && $fell(soft_gate_bit) |-> ##2 !internal_gate_flag)
      else $error("soft gate did not close");
   held_shut_a: assert property (
      s_held ##0 (plain && !internal_gate_flag) |=> !internal_gate_flag)
      else $error("gate reopened without an edge");
   frozen_a: assert property (
      (!internal_gate_flag && quiet && !cfg.isoMode) [*3]
      |=> $stable(countValue)) else $error("count moved while shut");
   step_up_a: assert property (
      plain && cfg.dir == gudc_pkg::DIR_NONE && cntPulse && cntUp
      && internal_gate_flag && $past(internal_gate_flag) && soft_gate_bit
      && !$past(cntPulse) && !$past(directCountWr) && !$past(cfgApply)
      && quiet && countValue != gudc_pkg::CNT_MAX ##1 quiet
      |=> countValue == $past(countValue, 2) + 32'sh1)
      else $error("up pulse did not add one");
   aux_level_a: assert property (
      ($stable(aux_input) && $stable(cfg) && !cfg.filterOn
      && cfg.auxFunc != gudc_pkg::AUXF_LATCH) [*8]
      |-> aux_input_level_flag == (aux_input ^ cfg.auxInvert))
      else $error("aux level flag wrong");
   ge_out_a: assert property (
      ($stable(countValue) && $stable(compare_value_one) && !cfg.isoMode
      && $stable(outCfgOne) && outCfgOne.enable
      && outCfgOne.fn == gudc_pkg::OUTF_GE) [*4]
      |-> output_one == (countValue >= compare_value_one))
      else $error("output one compare wrong");
   switch_two_a: assert property (
      (outCfgTwo.fn == gudc_pkg::OUTF_SWITCH) [*3] |-> !output_two)
      else $error("output two switched");
   cfg_reset_a: assert property (
      cfgApply && !cfg.isoMode |-> ##2 !internal_gate_flag && countValue
      == (cfg.dir == gudc_pkg::DIR_DOWN ? cfg.highLimit : 32'sh0))
      else $error("count not reset by config");
endmodule
bind gudc_counter gudc_counter_asserts u_chk (.clock, .rstn, .cfg,
   .cfgApply, .cntPulse, .cntUp, .soft_gate_bit, .directCountWr,
   .compare_value_one, .outCfgOne, .outCfgTwo, .aux_input, .output_one,
   .output_two, .countValue, .internal_gate_flag, .aux_input_level_flag);
`default_nettype wire

// ---- test/gudc_counter_tb.sv ----
// Purpose: directed bench for the gated up/down counter
// Assumes: inputs change on the falling clock edge
// Notes:   iso timing is checked here against the cycle model; the checker masks iso
`timescale 1ns/10ps
`default_nettype none
module gudc_counter_tb;
   logic clock = 0, rstn = 0, cfgApply = 0, cntPulse = 0, cntUp = 0;
   logic soft_gate_bit = 0, pendingLoadWr = 0, directCountWr = 0;
   logic aux_input = 0, outTick, inTick, output_one, output_two;
   logic internal_gate_flag, aux_input_level_flag;
   logic signed [31:0] pending_load_value = 0, direct_count_write = 0;
   logic signed [31:0] compare_value_one = 0, compare_value_two = 0;
   logic signed [31:0] countValue, latchValue;
   gudc_pkg::gudc_cfg_t cfg = '0;
   gudc_pkg::gudc_outcfg_t outCfgOne = '0, outCfgTwo = '0;
   int fail_count = 0, n_tests = 0;
   always #4 clock = ~clock;
   gudc_ctrl_model cm (.clock, .rstn, .outTick, .inTick);
   gudc_counter dut (.clock, .rstn, .cfg, .cfgApply, .cntPulse, .cntUp,
      .soft_gate_bit, .pendingLoadWr, .pending_load_value, .directCountWr,
      .direct_count_write, .compare_value_one, .compare_value_two,
      .outCfgOne, .outCfgTwo, .outTick, .inTick, .aux_input, .output_one,
      .output_two, .countValue, .latchValue, .internal_gate_flag,
      .aux_input_level_flag);
   task automatic cyc(int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(string s, logic signed [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
      end
   endtask
   task automatic apply(logic p, gudc_pkg::gudc_dir_t d, int h);
      cfg.mode = p ? gudc_pkg::MODE_PERIODIC : gudc_pkg::MODE_ONCE;
      cfg.dir = d;
      cfg.highLimit = 32'(h);
      cfgApply = 1;
      cyc(1);
      cfgApply = 0;
      cyc(2);
   endtask
   task automatic pul(logic u, int n);
      cntUp = u;
      cntPulse = 1;
      cyc(n);
      cntPulse = 0;
      cyc(3);
   endtask
   task automatic gate(logic v);
      soft_gate_bit = v;
      cyc(3);
   endtask
   task automatic wr(logic signed [31:0] v);
      direct_count_write = v;
      directCountWr = 1;
      cyc(1);
      directCountWr = 0;
      cyc(3);
   endtask
   task automatic ld(logic signed [31:0] v);
      pending_load_value = v;
      pendingLoadWr = 1;
      cyc(1);
      pendingLoadWr = 0;
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic signed [31:0] lim;
      int k;
      cyc(12);
      rstn = 1;
      cyc(1);
      apply(0, gudc_pkg::DIR_UP, 5);
      chk("count", 0, countValue);
      gate(1);
      chk("gate", 1, 32'(internal_gate_flag));
      pul(1, 4);
      pul(0, 1);
      chk("count", 3, countValue);
      pul(1, 2);
      chk("count", 0, countValue);
      chk("gate", 0, 32'(internal_gate_flag));
      pul(1, 1);
      chk("count", 0, countValue);
      gate(0);
      gate(1);
      pending_load_value = 32'sh2;
      pendingLoadWr = 1;
      cyc(1);
      pendingLoadWr = 0;
      pul(1, 5);
      chk("count", 2, countValue);
      $display("test once up done");
      for (int d = 0; d < 2; d++) begin
         apply(1, d ? gudc_pkg::DIR_DOWN : gudc_pkg::DIR_UP, 3);
         chk("count", d ? 3 : 0, countValue);
         gate(0);
         gate(1);
         pul(!d, 3);
         chk("count", d ? 3 : 0, countValue);
         chk("gate", 1, 32'(internal_gate_flag));
      end
      $display("test periodic done");
      for (int m = 0; m < 2; m++) begin
         apply(m, gudc_pkg::DIR_NONE, 0);
         gate(0);
         gate(1);
         pending_load_value = 32'sh7;
         pendingLoadWr = 1;
         cyc(1);
         pendingLoadWr = 0;
         pul(1, 2);
         pul(0, 1);
         chk("count", 1, countValue);
         for (int i = 0; i < 2; i++) begin
            lim = i ? gudc_pkg::CNT_MIN : gudc_pkg::CNT_MAX;
            wr(lim);
            pul(!i, 1);
            chk("count", m ? 7 : lim, countValue);
            chk("gate", m, 32'(internal_gate_flag));
            gate(0);
            gate(1);
         end
      end
      $display("test no direction done");
      aux_input = 1;
      apply(0, gudc_pkg::DIR_NONE, 0);
      cyc(8);
      chk("level", 1, 32'(aux_input_level_flag));
      cfg.auxInvert = 1;
      apply(0, gudc_pkg::DIR_NONE, 0);
      cyc(8);
      chk("level", 0, 32'(aux_input_level_flag));
      cfg.auxInvert = 0;
      cfg.filterOn = 1;
      cfg.filterCycles = 16'h0014;
      aux_input = 0;
      apply(0, gudc_pkg::DIR_NONE, 0);
      cyc(30);
      aux_input = 1;
      cyc(4);
      aux_input = 0;
      cyc(30);
      chk("level", 0, 32'(aux_input_level_flag));
      aux_input = 1;
      cyc(40);
      chk("level", 1, 32'(aux_input_level_flag));
      cfg.filterOn = 0;
      cfg.auxFunc = gudc_pkg::AUXF_GATE;
      aux_input = 0;
      apply(0, gudc_pkg::DIR_NONE, 0);
      gate(0);
      gate(1);
      chk("gate", 0, 32'(internal_gate_flag));
      aux_input = 1;
      cyc(10);
      chk("gate", 1, 32'(internal_gate_flag));
      pul(1, 1);
      chk("count", 1, countValue);
      aux_input = 0;
      cyc(10);
      chk("gate", 0, 32'(internal_gate_flag));
      $display("test aux input done");
      outCfgOne = '{gudc_pkg::OUTF_GE, 1'b1, 1'b0, 16'h0};
      outCfgTwo = '{gudc_pkg::OUTF_SWITCH, 1'b1, 1'b1, 16'h0};
      compare_value_one = 32'sh5;
      wr(32'sh5);
      chk("out1", 1, 32'(output_one));
      chk("out2", 0, 32'(output_two));
      wr(32'sh4);
      chk("out1", 0, 32'(output_one));
      outCfgOne.fn = gudc_pkg::OUTF_LE;
      outCfgTwo.fn = gudc_pkg::OUTF_PLAIN;
      cyc(3);
      chk("out1", 1, 32'(output_one));
      chk("out2", 1, 32'(output_two));
      outCfgOne = '{gudc_pkg::OUTF_PULSE, 1'b1, 1'b0, 16'h0004};
      wr(32'sh5);
      chk("out1", 1, 32'(output_one));
      cyc(4);
      chk("out1", 0, 32'(output_one));
      outCfgOne.fn = gudc_pkg::OUTF_SWITCH;
      compare_value_two = 32'sh4;
      wr(32'sh4);
      chk("out1", 0, 32'(output_one));
      wr(32'sh5);
      chk("out1", 1, 32'(output_one));
      $display("test outputs done");
      cfg.auxFunc = gudc_pkg::AUXF_INPUT;
      for (int g = 0; g < 3; g++) begin
         cfg.cancelGate = g == 0;
         cfg.loadOnOpen = g == 1;
         apply(0, gudc_pkg::DIR_UP, 100);
         ld(32'sh9);
         gate(0);
         gate(1);
         chk("count", g < 2 ? 9 : 0, countValue);
         pul(1, 2);
         gate(0);
         gate(1);
         chk("count", g < 2 ? 9 : 2, countValue);
      end
      cfg.auxFunc = gudc_pkg::AUXF_LATCH;
      apply(0, gudc_pkg::DIR_UP, 100);
      wr(32'sh6);
      aux_input = 1;
      cyc(10);
      chk("latch", 6, latchValue);
      aux_input = 0;
      $display("test gate function done");
      cfg.auxFunc = gudc_pkg::AUXF_INPUT;
      cfg.isoMode = 1;
      apply(0, gudc_pkg::DIR_UP, 100);
      gate(0);
      k = 0;
      while (!inTick && k < 40) begin
         cyc(1);
         k++;
      end
      if (!inTick) begin
         fail_count++;
         summarize;
      end
      soft_gate_bit = 1;
      cyc(3);
      chk("gate", 0, 32'(internal_gate_flag));
      cyc(10);
      chk("gate", 1, 32'(internal_gate_flag));
      pul(1, 3);
      cyc(16);
      chk("count", 3, countValue);
      $display("test isochronous done");
      summarize;
   end
   initial begin
      cyc(20000);
      fail_count++;
      summarize;
   end
endmodule
`default_nettype wire

// ---- test/gudc_ctrl_model.sv ----
// Purpose: bus controller timing, marks the instants of each bus cycle
// Assumes: one clock shared with the counter
// Notes:   output instant opens a cycle, input instant sits mid-cycle
`timescale 1ns/10ps
`default_nettype none
module gudc_ctrl_model #(
   parameter int PERIOD = 16
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rstn,
   // bus cycle instants
   output logic      outTick = 1'b0,
   output logic      inTick = 1'b0
);
   // ---------------------------------------------------------------
   // cycle timer
   // ---------------------------------------------------------------
   int phase = 0;
   // moves on the falling edge, clear of the counter's sampling edge
   always @(negedge clock) begin
      phase = (!rstn || phase == PERIOD - 1) ? 0 : phase + 1;
      outTick <= rstn && phase == 0;
      inTick <= rstn && phase == PERIOD / 2;
   end
endmodule
`default_nettype wire
